// [common/hbp_defines.vh]
// Constants for the host bus port: decode, control bits, reset values
`ifndef HBP_DEFINES_VH
`define HBP_DEFINES_VH
`define HBP_ADDR_W        3
`define HBP_DATA_W        8
`define HBP_NUM_REGS      8
`define HBP_REG_RESET     8'h00
`define HBP_CTRL_ADDR     3'h4
`define HBP_IRQ_OE_BIT    3
`define HBP_IR_SEL_BIT    6
`define HBP_STAT_ADDR     3'h5
`endif

// [verilog/hbp_sync2.v]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module hbp_sync2
#(
   parameter W = 1
)
(
   clock,
   nrst,
   d,
   q
);
   input  wire         clock;
   input  wire         nrst;
   input  wire [W-1:0] d;
   output reg  [W-1:0] q;

   reg [W-1:0] meta_reg;

   // Pins idle high; reset value matches so no false edges after reset
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         meta_reg <= {W{1'b1}};
         q        <= {W{1'b1}};
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

// [verilog/hbp_host_port.v]
// Host parallel bus port: strobe or direction-line style, interrupt pin, TX idle level
// Overview of operation
// - Strobe mode: read low starts register read
// - Strobe mode: write falling edge begins write
// - Strobe mode: write rising edge latches data bus
// - Direction-line mode: write pin is direction
// - Reads and strobe writes while chip select low; direction-line write on its release
// - Strobe mode: interrupt active high
// - Strobe mode: interrupt enable drives or floats
// - Direction-line mode: interrupt open-drain active low
// - Normal serial: transmit idles high
// - Infrared: transmit idles low, encoder routed
// - Three address lines pick eight registers
// - Eight-bit bidirectional data bus
`timescale 1ns/1ns
`include "hbp_defines.vh"
module hbp_host_port
(
   clock,
   nrst,
   bus_style,
   chip_select_n,
   read_strobe_n,
   write_strobe_n,
   reg_addr,
   data_in,
   data_out,
   data_oe_n,
   irq_req,
   irq_out,
   irq_oe_n,
   tx_busy,
   tx_serial,
   tx_ir,
   tx_out
);
   input  wire                   clock;
   input  wire                   nrst;
   input  wire                   bus_style;
   input  wire                   chip_select_n;
   input  wire                   read_strobe_n;
   input  wire                   write_strobe_n;
   input  wire [`HBP_ADDR_W-1:0] reg_addr;
   input  wire [`HBP_DATA_W-1:0] data_in;
   output reg  [`HBP_DATA_W-1:0] data_out;
   output reg                    data_oe_n;
   input  wire                   irq_req;
   output reg                    irq_out;
   output reg                    irq_oe_n;
   input  wire                   tx_busy;
   input  wire                   tx_serial;
   input  wire                   tx_ir;
   output reg                    tx_out;

   // ==========================================
   // Pin synchronisers
   // ==========================================
   wire [14:0] pins_s;
   hbp_sync2 #(.W(15)) u_sync
   (
      .clock (clock),
      .nrst  (nrst),
      .d     ({bus_style, chip_select_n, read_strobe_n, write_strobe_n, reg_addr, data_in}),
      .q     (pins_s)
   );
   wire                   style_s = pins_s[14];
   wire                   cs_n_s  = pins_s[13];
   wire                   rd_n_s  = pins_s[12];
   wire                   wr_n_s  = pins_s[11];
   wire [`HBP_ADDR_W-1:0] addr_s  = pins_s[10:8];
   wire [`HBP_DATA_W-1:0] din_s   = pins_s[7:0];

   reg rd_n_d_reg;
   reg wr_n_d_reg;
   reg cs_n_d_reg;
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         rd_n_d_reg <= 1'b1;
         wr_n_d_reg <= 1'b1;
         cs_n_d_reg <= 1'b1;
      end
      else
      begin
         rd_n_d_reg <= rd_n_s;
         wr_n_d_reg <= wr_n_s;
         cs_n_d_reg <= cs_n_s;
      end
   end

   // ==========================================
   // Access decode
   // ==========================================
   wire strobe_mode = style_s;
   wire sel = ~cs_n_s;
   wire rd_strobe = strobe_mode & sel & ~rd_n_s;
   wire wr_fall = strobe_mode & sel & wr_n_d_reg & ~wr_n_s;
   wire wr_rise = strobe_mode & sel & ~wr_n_d_reg & wr_n_s;
   wire dl_read = ~strobe_mode & sel & wr_n_s;
   wire dl_write = ~strobe_mode & cs_n_s & ~cs_n_d_reg & ~wr_n_d_reg;
   // Read line ignored in direction-line mode, host ties it high

   reg wr_armed_reg;
   always @(posedge clock)
   begin
      if (!nrst)
         wr_armed_reg <= 1'b0;
      else if (wr_fall)
         wr_armed_reg <= 1'b1;
      else if (wr_rise | ~strobe_mode)
         wr_armed_reg <= 1'b0;
   end

   // ==========================================
   // Register storage
   // ==========================================
   reg [`HBP_DATA_W-1:0] regs [0:`HBP_NUM_REGS-1];
   reg [`HBP_ADDR_W-1:0] dl_addr_reg;
   reg [`HBP_DATA_W-1:0] dl_data_reg;
   wire [`HBP_DATA_W-1:0] ctrl = regs[`HBP_CTRL_ADDR];
   integer i;

   // Direction-line data sampled while selected; last value wins at release
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         dl_addr_reg <= {`HBP_ADDR_W{1'b0}};
         dl_data_reg <= `HBP_REG_RESET;
      end
      else if (sel & ~strobe_mode)
      begin
         dl_addr_reg <= addr_s;
         dl_data_reg <= din_s;
      end
   end

   always @(posedge clock)
   begin
      if (!nrst)
      begin
         for (i = 0; i < `HBP_NUM_REGS; i = i + 1)
            regs[i] <= `HBP_REG_RESET;
      end
      else
      begin
         if (wr_rise & wr_armed_reg)
            regs[addr_s] <= din_s;
         else if (dl_write)
            regs[dl_addr_reg] <= dl_data_reg;
      end
   end

   // Status location shows live block state, not stored data
   wire [`HBP_DATA_W-1:0] status = {5'h00, tx_busy, irq_req, strobe_mode};
   wire [`HBP_DATA_W-1:0] rd_val = (addr_s == `HBP_STAT_ADDR) ? status : regs[addr_s];

   // ==========================================
   // Data bus drive
   // ==========================================
   // Drive only on reads
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         data_out  <= `HBP_REG_RESET;
         data_oe_n <= 1'b1;
      end
      else if (rd_strobe | dl_read)
      begin
         data_out  <= rd_val;
         data_oe_n <= 1'b0;
      end
      else
      begin
         data_out  <= data_out;
         data_oe_n <= 1'b1;
      end
   end

   // ==========================================
   // Interrupt pin
   // ==========================================
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         irq_out  <= 1'b0;
         irq_oe_n <= 1'b1;
      end
      else if (strobe_mode)
      begin
         irq_out  <= irq_req;
         irq_oe_n <= ~ctrl[`HBP_IRQ_OE_BIT];
      end
      else
      begin
         irq_out  <= 1'b0;
         irq_oe_n <= ~irq_req;
      end
   end

   // ==========================================
   // Transmit pin
   // ==========================================
   always @(posedge clock)
   begin
      if (!nrst)
         tx_out <= 1'b1;
      else if (ctrl[`HBP_IR_SEL_BIT])
         tx_out <= tx_busy & tx_ir;
      else
         tx_out <= ~tx_busy | tx_serial;
   end
endmodule

// [verification/hbp_properties.sv]
// Pin-level assertions for the host bus port
`timescale 1ns/1ns
module hbp_props
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic bus_style,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic data_oe_n,
   input wire logic irq_req,
   input wire logic irq_out,
   input wire logic irq_oe_n,
   input wire logic tx_busy,
   input wire logic tx_serial,
   input wire logic tx_ir,
   input wire logic tx_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_read_drive: assert property (
      (bus_style && !chip_select_n && !read_strobe_n)[*4] |=> !data_oe_n) else $error("no drive");
   a_deselect_float: assert property (
      chip_select_n[*4] |=> data_oe_n) else $error("driven while deselected");
   a_dir_write_float: assert property (
      (!bus_style && !write_strobe_n)[*4] |=> data_oe_n) else $error("driven on write");
   a_dir_read_drive: assert property (
      (!bus_style && write_strobe_n && !chip_select_n)[*4] |=> !data_oe_n) else $error("no drive");
   a_irq_high: assert property (
      bus_style[*4] |=> irq_out == $past(irq_req)) else $error("irq level wrong");
   a_irq_drain: assert property (
      (!bus_style)[*4] |=> !irq_out && irq_oe_n == !$past(irq_req)) else $error("irq drain wrong");
   a_tx_follow: assert property (
      tx_busy && tx_serial == tx_ir |=> tx_out == $past(tx_serial)) else $error("tx bit wrong");
   a_reset_idle: assert property (disable iff (1'b0)
      !nrst |=> tx_out && data_oe_n && irq_oe_n && !irq_out) else $error("reset levels wrong");
endmodule
bind hbp_host_port hbp_props u_props (.*);

// [verification/hbp_host.sv]
// Host processor model for both bus styles
`timescale 1ns/1ns
module hbp_host
(
   input  wire logic       clock,
   input  wire logic       bus_style,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_n,
   output logic            chip_select_n,
   output logic            read_strobe_n,
   output logic            write_strobe_n,
   output logic      [2:0] reg_addr,
   output wire logic [7:0] data_in
);
   logic [7:0] hd = 8'h5a;
   logic       drv = 1'b0;
   initial
   begin
      chip_select_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      reg_addr = 3'h0;
   end
   assign data_in = data_oe_n ? hd : data_out;
   always @(posedge clock)
      if (!drv)
         hd <= ~hd;
   // Select frames access, byte taken at release
   task automatic acc(input bit w, input bit sel, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clock) #2;
      reg_addr = a;
      chip_select_n = !sel;
      drv = w;
      hd = d;
      if (!bus_style)
         write_strobe_n = !w;
      @(posedge clock) #2;
      if (bus_style)
         {write_strobe_n, read_strobe_n} = {!w, w};
      repeat (4) @(posedge clock);
      #2;
      q = data_in;
      read_strobe_n = 1'b1;
      if (bus_style)
         write_strobe_n = 1'b1;
      @(posedge clock) #2;
      chip_select_n = 1'b1;
      drv = 1'b0;
      repeat (5) @(posedge clock);
      // Return off the edge so callers never race the design's registers
      #2;
   endtask
endmodule

// [verification/tb.sv]
// Bench for the host bus port against a reference byte store
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
$display("Error %0t %h %h", $time, a, b); end end
module tb;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        bus_style = 1'b1;
   logic        irq_req = 1'b0;
   logic        tx_busy = 1'b0;
   logic        tx_serial = 1'b0;
   logic        tx_ir = 1'b0;
   logic [31:0] seed = 32'd99;
   logic [7:0]  mem [8] = '{default: 8'h00};
   logic [7:0]  d;
   logic [7:0]  rd;
   logic [2:0]  a;
   int          err_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   wire         chip_select_n, read_strobe_n, write_strobe_n, data_oe_n;
   wire         irq_out, irq_oe_n, tx_out;
   wire  [2:0]  reg_addr;
   wire  [7:0]  data_in, data_out;
   hbp_host_port dut (.*);
   hbp_host u_host (.*);
   always #10 clock = ~clock;
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic close_out();
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Two bus styles of 24 accesses pairs fit well inside this
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (20) @(posedge clock);
      #2;
      `CHK({tx_out, data_oe_n}, 2'b11)
      nrst = 1'b1;
      for (int m = 1; m >= 0; m--)
      begin
         bus_style = m[0];
         repeat (4) @(posedge clock);
         #2;
         for (int i = 0; i < 24; i++)
         begin
            a = 3'(xs());
            d = xs();
            {tx_ir, tx_serial, tx_busy, irq_req} = d[3:0];
            u_host.acc(1'b1, i % 4 != 0, a, d, rd);
            if (i % 4 != 0)
               mem[a] = d;
            u_host.acc(1'b0, 1'b1, a, d, rd);
            if (a == 3'h5) `CHK(rd, {5'h00, tx_busy, irq_req, bus_style})
            else `CHK(rd, mem[a])
            if (m) `CHK({irq_oe_n, irq_out}, {~mem[4][3], irq_req})
            else `CHK({irq_oe_n, irq_out}, {~irq_req, 1'b0})
            `CHK(tx_out, tx_busy ? (mem[4][6] ? tx_ir : tx_serial) : ~mem[4][6])
         end
      end
      close_out();
   end
endmodule
